//--- dspm_pin_mux.sv
/*
  Pin mux for the two shared decoder pins (phase B and marker). Each pin
  carries the decoder input, a timer B channel, a second-SPI data line or a
  port C line. Includes the SPI data line launch timing and tri-state.
  Assumes the SPI engine runs its serial clock from this module's strobes
  and that timer / GPIO engines are outside; pads resolve from the enables.
*/
`timescale 1ns/1ps
`include "dspm_regs.svh"

module dspm_pin_mux #(
  parameter int HALF_CYC = `DSPM_HALF_DEF  // System clocks per half SCK
) (
  input  wire logic                      mclk_in,       // 40 MHz clock
  input  wire logic                      rst_b_in,      // Async reset, low
  input  wire dspm_pkg::dspm_sel_t       sel_in,        // Function selects
  input  wire logic [`DSPM_PUR_W-1:0]    pullup_reg_in, // Port C pull-ups
  input  wire logic                      gpio_en1_in,   // Pin1 as port C
  input  wire logic                      gpio_en2_in,   // Pin2 as port C
  input  wire logic                      tmr_en1_in,    // Pin1 as timer
  input  wire logic                      tmr_en2_in,    // Pin2 as timer
  input  wire logic [1:0]                gpio_out_in,   // Port C out data
  input  wire logic [1:0]                gpio_oe_in,    // Port C out enable
  input  wire logic [1:0]                tmr_out_in,    // Timer out data
  input  wire logic [1:0]                tmr_oe_in,     // Timer out enable
  input  wire logic                      spi_master_in, // SPI is master
  input  wire logic                      spi_sel_in,    // Slave selected
  input  wire logic                      spi_bit_in,    // Next bit to send
  input  wire logic                      spi_run_in,    // Transfer active
  input  wire logic                      pin1_in,       // Pin 1 level
  input  wire logic                      pin2_in,       // Pin 2 level
  output logic                           pin1_out,      // Pin 1 drive level
  output logic                           pin1_oe_out,   // Pin 1 enable
  output logic                           pin2_out,      // Pin 2 drive level
  output logic                           pin2_oe_out,   // Pin 2 enable
  output logic                           pu1_en_out,    // Pin 1 pull-up on
  output logic                           pu2_en_out,    // Pin 2 pull-up on
  output logic                           phase_b_out,   // To decoder
  output logic                           marker_out,    // To decoder
  output logic [1:0]                     tmr_in_out,    // To timer
  output logic [1:0]                     gpio_in_out,   // To port C
  output logic                           spi_rx_out,    // Data to SPI
  output logic                           spi_launch_out,// Bit launched
  output logic                           spi_sample_out,// Sample edge
  output dspm_pkg::dspm_fn_t             fn1_out,       // Pin 1 function
  output dspm_pkg::dspm_fn_t             fn2_out        // Pin 2 function
);
  import dspm_pkg::*;

  localparam int CW = $clog2(HALF_CYC + 1);
  // Pull-up reset word, so each pin's reset level is one bit of it
  localparam logic [`DSPM_PUR_W-1:0] PUR_RST = `DSPM_PUR_RST;

  // Decode the function of a pin, SPI select winning over the others
  function automatic dspm_fn_t pick_fn(input logic spi, input logic gpio,
                                       input logic tmr);
    if (spi) begin
      pick_fn = DSPM_FN_SPI;
    end else if (gpio) begin
      pick_fn = DSPM_FN_GPIO;
    end else if (tmr) begin
      pick_fn = DSPM_FN_TIMER;
    end else begin
      pick_fn = DSPM_FN_DECODER;
    end
  endfunction

  // Serial timing phase: launch half, then sample half
  typedef enum logic [1:0] {
    SP_IDLE,
    SP_LAUNCH,
    SP_SAMPLE
  } dspm_sp_t;

  dspm_sp_t        sp_r, sp_nxt;            // Serial phase
  logic [CW-1:0]   cnt_r, cnt_nxt;          // Half-period counter
  logic            dat_r, dat_nxt;          // Launched data bit
  logic            launch_r, launch_nxt;    // Launch strobe
  logic            sample_r, sample_nxt;    // Sample strobe
  logic            rx_r, rx_nxt;            // Sampled receive bit
  dspm_fn_t        fn1_r, fn1_nxt;          // Pin 1 function
  dspm_fn_t        fn2_r, fn2_nxt;          // Pin 2 function
  dspm_pad_t       p1_r, p1_nxt;            // Pin 1 drive
  dspm_pad_t       p2_r, p2_nxt;            // Pin 2 drive
  logic            pu1_r, pu1_nxt;          // Pull-up 1
  logic            pu2_r, pu2_nxt;          // Pull-up 2
  logic            phb_r, phb_nxt;          // Decoder phase B
  logic            mrk_r, mrk_nxt;          // Decoder marker
  logic [1:0]      tin_r, tin_nxt;          // Timer inputs
  logic [1:0]      gin_r, gin_nxt;          // Port C inputs
  logic            tx_ok;                   // This end may drive data

  // Serial timing: data changes one half period before the sample edge
  always_comb begin
    sp_nxt     = sp_r;
    cnt_nxt    = cnt_r;
    dat_nxt    = dat_r;
    launch_nxt = 1'b0;
    sample_nxt = 1'b0;
    case (sp_r)
      SP_IDLE: begin
        // Start of transfer: launch first bit now
        if (spi_run_in) begin
          dat_nxt    = spi_bit_in;
          launch_nxt = 1'b1;
          cnt_nxt    = CW'(HALF_CYC - 1);
          sp_nxt     = SP_LAUNCH;
        end
      end
      SP_LAUNCH: begin
        // Hold data a half period, then sample edge
        if (cnt_r == '0) begin
          sample_nxt = 1'b1;
          cnt_nxt    = CW'(HALF_CYC - 1);
          sp_nxt     = SP_SAMPLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      SP_SAMPLE: begin
        // Second half: next launch or idle
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (spi_run_in) begin
          dat_nxt    = spi_bit_in;
          launch_nxt = 1'b1;
          cnt_nxt    = CW'(HALF_CYC - 1);
          sp_nxt     = SP_LAUNCH;
        end else begin
          sp_nxt = SP_IDLE;
        end
      end
      default: begin
        sp_nxt = SP_IDLE;
      end
    endcase
  end

  // Pin routing, pull-ups and input fan-out
  always_comb begin
    fn1_nxt = pick_fn(sel_in.phase_b_spi_select, gpio_en1_in, tmr_en1_in);
    fn2_nxt = pick_fn(sel_in.marker_pin_spi_select, gpio_en2_in, tmr_en2_in);
    tx_ok   = spi_master_in | spi_sel_in;
    rx_nxt  = rx_r;
    p1_nxt  = '{in: pin1_in, out: 1'b0, oe: 1'b0};
    p2_nxt  = '{in: pin2_in, out: 1'b0, oe: 1'b0};
    case (fn1_nxt)
      DSPM_FN_SPI: begin
        p1_nxt.out = dat_r;
        p1_nxt.oe  = spi_master_in;
        if (sample_r && !spi_master_in) begin
          rx_nxt = pin1_in;
        end
      end
      DSPM_FN_TIMER: begin
        p1_nxt.out = tmr_out_in[0];
        p1_nxt.oe  = tmr_oe_in[0];
      end
      DSPM_FN_GPIO: begin
        p1_nxt.out = gpio_out_in[0];
        p1_nxt.oe  = gpio_oe_in[0];
      end
      default: begin
        p1_nxt.oe = 1'b0;
      end
    endcase
    case (fn2_nxt)
      DSPM_FN_SPI: begin
        p2_nxt.out = dat_r;
        p2_nxt.oe  = !spi_master_in && tx_ok;
        if (sample_r && spi_master_in) begin
          rx_nxt = pin2_in;
        end
      end
      DSPM_FN_TIMER: begin
        p2_nxt.out = tmr_out_in[1];
        p2_nxt.oe  = tmr_oe_in[1];
      end
      DSPM_FN_GPIO: begin
        p2_nxt.out = gpio_out_in[1];
        p2_nxt.oe  = gpio_oe_in[1];
      end
      default: begin
        p2_nxt.oe = 1'b0;
      end
    endcase
    pu1_nxt = pullup_reg_in[`DSPM_PUR_PIN1_BIT];
    pu2_nxt = pullup_reg_in[`DSPM_PUR_PIN2_BIT];
    phb_nxt = (fn1_nxt == DSPM_FN_DECODER) ? pin1_in : 1'b0;
    mrk_nxt = (fn2_nxt == DSPM_FN_DECODER) ? pin2_in : 1'b0;
    tin_nxt = {(fn2_nxt == DSPM_FN_TIMER) & pin2_in,
               (fn1_nxt == DSPM_FN_TIMER) & pin1_in};
    gin_nxt = {(fn2_nxt == DSPM_FN_GPIO) & pin2_in,
               (fn1_nxt == DSPM_FN_GPIO) & pin1_in};
  end

  // Register all state; reset gives decoder function, pins undriven
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sp_r     <= SP_IDLE;
      cnt_r    <= '0;
      dat_r    <= 1'b0;
      launch_r <= 1'b0;
      sample_r <= 1'b0;
      rx_r     <= 1'b0;
      fn1_r    <= DSPM_FN_DECODER;
      fn2_r    <= DSPM_FN_DECODER;
      p1_r     <= '0;
      p2_r     <= '0;
      pu1_r    <= PUR_RST[`DSPM_PUR_PIN1_BIT];
      pu2_r    <= PUR_RST[`DSPM_PUR_PIN2_BIT];
      phb_r    <= 1'b0;
      mrk_r    <= 1'b0;
      tin_r    <= '0;
      gin_r    <= '0;
    end else begin
      sp_r     <= sp_nxt;
      cnt_r    <= cnt_nxt;
      dat_r    <= dat_nxt;
      launch_r <= launch_nxt;
      sample_r <= sample_nxt;
      rx_r     <= rx_nxt;
      fn1_r    <= fn1_nxt;
      fn2_r    <= fn2_nxt;
      p1_r     <= p1_nxt;
      p2_r     <= p2_nxt;
      pu1_r    <= pu1_nxt;
      pu2_r    <= pu2_nxt;
      phb_r    <= phb_nxt;
      mrk_r    <= mrk_nxt;
      tin_r    <= tin_nxt;
      gin_r    <= gin_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign pin1_out       = p1_r.out;
  assign pin1_oe_out    = p1_r.oe;
  assign pin2_out       = p2_r.out;
  assign pin2_oe_out    = p2_r.oe;
  assign pu1_en_out     = pu1_r;
  assign pu2_en_out     = pu2_r;
  assign phase_b_out    = phb_r;
  assign marker_out     = mrk_r;
  assign tmr_in_out     = tin_r;
  assign gpio_in_out    = gin_r;
  assign spi_rx_out     = rx_r;
  assign spi_launch_out = launch_r;
  assign spi_sample_out = sample_r;
  assign fn1_out        = fn1_r;
  assign fn2_out        = fn2_r;
endmodule

//--- dspm_pin_mux_chk.sv
/* Checker for the decoder / SPI pin mux: routing, pull-ups, timing.
   Assumes it is bound to dspm_pin_mux and sees only its ports. */
`timescale 1ns/1ps
module dspm_pin_mux_chk
  import dspm_pkg::*;
#(
  parameter int HALF_CYC = 8                 // Clocks per half SCK
) (
  input wire logic        mclk_in,           // Clock
  input wire logic        rst_b_in,          // Reset, low
  input wire dspm_sel_t   sel_in,            // Function selects
  input wire logic [15:0] pullup_reg_in,     // Port C pull-ups
  input wire logic        gpio_en1_in,       // Pin 1 port C
  input wire logic        tmr_en1_in,        // Pin 1 timer
  input wire logic        spi_master_in,     // SPI is master
  input wire logic        spi_sel_in,        // Slave selected
  input wire logic        pin1_oe_out,       // Pin 1 enable
  input wire logic        pin2_oe_out,       // Pin 2 enable
  input wire logic        pu1_en_out,        // Pin 1 pull-up
  input wire logic        pu2_en_out,        // Pin 2 pull-up
  input wire logic        spi_launch_out,    // Launch pulse
  input wire logic        spi_sample_out,    // Sample pulse
  input wire dspm_fn_t    fn1_out,           // Pin 1 function
  input wire dspm_fn_t    fn2_out            // Pin 2 function
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // Bit launched on the line, then sampled half a period later
  sequence launch_s; spi_launch_out; endsequence
  sequence sample_s; ##HALF_CYC spi_sample_out; endsequence
  dflt_pin1_a:
    assert property ($rose(rst_b_in) |-> fn1_out == DSPM_FN_DECODER)
    else $error("pin 1 not decoder after reset");
  dflt_pin2_a:
    assert property ($rose(rst_b_in) |-> fn2_out == DSPM_FN_DECODER)
    else $error("pin 2 not decoder after reset");
  mosi_route_a:
    assert property (sel_in.phase_b_spi_select |=> fn1_out == DSPM_FN_SPI)
    else $error("pin 1 not routed to SPI");
  miso_route_a:
    assert property (sel_in.marker_pin_spi_select |=> fn2_out == DSPM_FN_SPI)
    else $error("pin 2 not routed to SPI");
  pu_pin1_a:
    assert property (1 |=> pu1_en_out == $past(pullup_reg_in[1]))
    else $error("pin 1 pull-up wrong");
  pu_pin2_a:
    assert property (!pullup_reg_in[2] |=> !pu2_en_out)
    else $error("pin 2 pull-up not off");
  half_cyc_a:
    assert property (launch_s |-> sample_s)
    else $error("sample not half a period after launch");
  spi_off_a:
    assert property (!sel_in.phase_b_spi_select && !gpio_en1_in &&
                     !tmr_en1_in |=> !pin1_oe_out)
    else $error("pin 1 driven without select");
  unsel_hiz_a:
    assert property (sel_in.marker_pin_spi_select && !spi_master_in &&
                     !spi_sel_in |=> !pin2_oe_out)
    else $error("unselected slave drives pin 2");
endmodule
bind dspm_pin_mux dspm_pin_mux_chk #(.HALF_CYC(HALF_CYC)) u_chk (
  .mclk_in, .rst_b_in, .sel_in, .pullup_reg_in, .gpio_en1_in, .tmr_en1_in,
  .spi_master_in, .spi_sel_in, .pin1_oe_out, .pin2_oe_out, .pu1_en_out,
  .pu2_en_out, .spi_launch_out, .spi_sample_out, .fn1_out, .fn2_out);

//--- dspm_pkg.sv
/*
  Types of the decoder / SPI pin mux.
  Assumes the constants header sits in the same folder.
*/
`include "dspm_regs.svh"

package dspm_pkg;
  // Function carried by one shared pin
  typedef enum logic [1:0] {
    DSPM_FN_DECODER,
    DSPM_FN_TIMER,
    DSPM_FN_SPI,
    DSPM_FN_GPIO
  } dspm_fn_t;

  // Three-signal pad view: input level, output level, output enable
  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } dspm_pad_t;

  // Pin function select bits
  typedef struct packed {
    logic phase_b_spi_select;
    logic marker_pin_spi_select;
  } dspm_sel_t;
endpackage

//--- dspm_regs.svh
/*
  Constants of the decoder / SPI pin mux: pull-up width and bit positions, select and pull-up
  reset values and serial data line timing figures.
  Assumes inclusion by bare name from the package and the mux module.
*/
// How it works
// - Reset: first pin feeds decoder phase B
// - Reset: second pin feeds decoder marker input
// - Phase-B select routes SPI master-out onto pin
// - Marker select routes SPI master-in onto pin
// - Port C bit 1 clear disables pin one pull-up
// - Port C bit 2 clear disables pin two pull-up
// - Master drives data half cycle before sampling
// - Unselected slave leaves master-in line undriven
// - Slave drives data half cycle before sampling
`ifndef DSPM_REGS_SVH
`define DSPM_REGS_SVH

// Port C pull-up control register width and bit positions
`define DSPM_PUR_W         16
`define DSPM_PUR_PIN1_BIT  1
`define DSPM_PUR_PIN2_BIT  2
// Pull-ups enabled out of reset
`define DSPM_PUR_RST       16'hffff
// Select bits clear out of reset
`define DSPM_SEL_RST       1'h0
// Half a serial clock period, in system clocks
`define DSPM_HALF_DEF      8

`endif

//--- dspm_spi_peer.sv
/* Far-side model: encoder levels or SPI peer on the two shared pins.
   Assumes the bench resolves each pin from all parties' enables. */
`timescale 1ns/1ps
module dspm_spi_peer (
  input  wire logic mclk_in,   // Clock
  input  wire logic launch_in, // Serial launch edge
  input  wire logic busy_in,   // In a frame
  input  wire logic bit_in,    // Next bit to send
  input  wire logic en1_in,    // Drive pin 1
  input  wire logic en2_in,    // Drive pin 2
  output logic      pin1_out,  // Pin 1 level
  output logic      pin2_out,  // Pin 2 level
  output logic      oe1_out,   // Pin 1 driven
  output logic      oe2_out    // Pin 2 driven
);
  logic bit_r;                 // Bit on the line
  // New bit at launch, half a period before sample
  always_ff @(posedge mclk_in) begin
    if (launch_in || !busy_in) begin
      bit_r <= bit_in;
    end
  end
  // Released line shows the inverse of the last bit
  assign pin1_out = en1_in ? bit_r : ~bit_r;
  assign pin2_out = en2_in ? bit_r : ~bit_r;
  assign oe1_out  = en1_in;
  assign oe2_out  = en2_in;
endmodule

//--- tb_top.sv
/* Self-checking bench of the decoder / SPI pin mux.
   Assumes the checker is bound and the peer model sits on the pins. */
`timescale 1ns/1ps
module tb_top;
  import dspm_pkg::*;
  localparam int HC = 2;                   // Short half period
  logic mclk_in = 1'b0, rst_b_in = 1'b0, spi_master_in = 1'b0;
  logic spi_sel_in = 1'b0, spi_bit_in = 1'b0, spi_run_in = 1'b0;
  logic gpio_en1_in, gpio_en2_in, tmr_en1_in, tmr_en2_in, pin1_in, pin2_in;
  logic [1:0] gpio_out_in, gpio_oe_in, tmr_out_in, tmr_oe_in;
  logic [1:0] tmr_in_out, gpio_in_out;
  logic [15:0] pullup_reg_in = 16'hffff;
  dspm_sel_t sel_in = 2'h0;
  logic pin1_out, pin1_oe_out, pin2_out, pin2_oe_out, pu1_en_out, pu2_en_out;
  logic phase_b_out, marker_out, spi_rx_out, spi_launch_out, spi_sample_out;
  dspm_fn_t fn1_out, fn2_out;
  logic p1, p2, po1, po2, pbit = 1'b0, pbusy = 1'b0, pen1 = 1'b0, pen2 = 1'b0;
  logic noise = 1'b0, pend = 1'b0;         // Random side inputs, rx due
  logic [11:0] side = 12'h0;               // Held side inputs
  logic [31:0] lf = 32'hb910;              // Random source
  logic qt[$], qr[$];                      // Expected wire and rx bits
  int mismatches = 0, comparisons = 0, cyc = 0;
  assign {gpio_en1_in, gpio_en2_in, tmr_en1_in, tmr_en2_in, gpio_out_in,
          gpio_oe_in, tmr_out_in, tmr_oe_in} = noise ? lf[11:0] : side;
  // Pad resolution: design, then peer, then pull-up
  assign pin1_in = pin1_oe_out ? pin1_out : (po1 || !pu1_en_out) ? p1 : 1'b1;
  assign pin2_in = pin2_oe_out ? pin2_out : (po2 || !pu2_en_out) ? p2 : 1'b1;
  dspm_pin_mux #(.HALF_CYC(HC)) u_dspm_pin_mux (.mclk_in, .rst_b_in, .sel_in,
    .pullup_reg_in, .gpio_en1_in, .gpio_en2_in, .tmr_en1_in, .tmr_en2_in,
    .gpio_out_in, .gpio_oe_in, .tmr_out_in, .tmr_oe_in, .spi_master_in,
    .spi_sel_in, .spi_bit_in, .spi_run_in, .pin1_in, .pin2_in, .pin1_out,
    .pin1_oe_out, .pin2_out, .pin2_oe_out, .pu1_en_out, .pu2_en_out,
    .phase_b_out, .marker_out, .tmr_in_out, .gpio_in_out, .spi_rx_out,
    .spi_launch_out, .spi_sample_out, .fn1_out, .fn2_out);
  dspm_spi_peer u_dspm_spi_peer (.mclk_in, .launch_in(spi_launch_out),
    .busy_in(pbusy), .bit_in(pbit), .en1_in(pen1), .en2_in(pen2),
    .pin1_out(p1), .pin2_out(p2), .oe1_out(po1), .oe2_out(po2));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected pin function: port C over timer over decoder
  function automatic dspm_fn_t efn(input logic g, input logic t);
    return g ? DSPM_FN_GPIO : t ? DSPM_FN_TIMER : DSPM_FN_DECODER;
  endfunction
  task automatic cmp(input logic a, input logic e);
    comparisons++;
    if (a !== e) begin
      mismatches++;
      $display("MISMATCH %0t bit %b expected %b", $time, a, e);
    end
  endtask
  task automatic cmpf(input dspm_fn_t a, input dspm_fn_t e);
    comparisons++;
    if (a !== e) begin
      mismatches++;
      $display("MISMATCH %0t function %0d expected %0d", $time, a, e);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One SPI bit per pass; notes the wire and receive expectations
  task automatic xfer(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk_in);
      spi_bit_in <= lf[3];
      pbit <= lf[7];
      spi_run_in <= 1'b1;
      qt.push_back(lf[3]);
      qr.push_back(lf[7]);
      for (int k = 0; k < 8 && spi_launch_out !== 1'b1; k++) begin
        @(posedge mclk_in);
      end
      spi_run_in <= 1'b0;
      repeat (2 * HC + 1) @(posedge mclk_in);
    end
  endtask
  initial begin
    forever #12.5 mclk_in = ~mclk_in;
  end
  // Random source, cycle ceiling
  always @(posedge mclk_in) begin
    lf <= lfsr(lf);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  // Watcher: wire level at the sample pulse, received bit a cycle later
  always @(negedge mclk_in) begin
    if (pend) cmp(spi_rx_out, qr.pop_front());
    pend = spi_sample_out;
    if (spi_sample_out) begin
      cmp(spi_master_in ? pin1_in : pin2_in, qt.pop_front());
    end
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    pen1 <= 1'b1;
    pen2 <= 1'b1;
    // Decoder defaults follow the encoder levels
    repeat (4) begin
      @(posedge mclk_in);
      pbit <= lf[0];
      repeat (3) @(posedge mclk_in);
      cmp(phase_b_out, pbit);
      cmp(marker_out, pbit);
      cmpf(fn1_out, DSPM_FN_DECODER);
      cmpf(fn2_out, DSPM_FN_DECODER);
    end
    // Pull-up bits in every combination
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in);
      pullup_reg_in <= {lf[15:3], i[1:0], lf[0]};
      repeat (2) @(posedge mclk_in);
      cmp(pu1_en_out, i[0]);
      cmp(pu2_en_out, i[1]);
    end
    // Port C and timer functions from random enables, decoder if none
    repeat (4) begin
      @(posedge mclk_in);
      side <= lf[11:0];
      repeat (3) @(posedge mclk_in);
      cmpf(fn1_out, efn(side[11], side[9]));
      cmpf(fn2_out, efn(side[10], side[8]));
      cmp(pin1_oe_out, side[11] ? side[4] : side[9] & side[0]);
      cmp(pin2_oe_out, side[10] ? side[5] : side[8] & side[1]);
      cmp(phase_b_out, !side[11] & !side[9] & pin1_in);
      cmp(marker_out, !side[10] & !side[8] & pin2_in);
      cmp(gpio_in_out[0], side[11] & pin1_in);
      cmp(gpio_in_out[1], side[10] & pin2_in);
      cmp(tmr_in_out[0], !side[11] & side[9] & pin1_in);
      cmp(tmr_in_out[1], !side[10] & side[8] & pin2_in);
    end
    side <= 12'h0;
    spi_master_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    cmp(pin1_oe_out, 1'b0);
    sel_in <= 2'h3;
    pen1 <= 1'b0;
    pbusy <= 1'b1;
    noise <= 1'b1;
    repeat (2) @(posedge mclk_in);
    cmpf(fn1_out, DSPM_FN_SPI);
    cmpf(fn2_out, DSPM_FN_SPI);
    xfer(8);
    spi_master_in <= 1'b0;
    pen1 <= 1'b1;
    pen2 <= 1'b0;
    repeat (3) @(posedge mclk_in);
    cmp(pin2_oe_out, 1'b0);
    spi_sel_in <= 1'b1;
    xfer(8);
    repeat (4) @(posedge mclk_in);
    cmp(qt.size() == 0 && qr.size() == 0, 1'b1);
    end_of_test();
  end
endmodule
